// ===== dcc_map.vh
// dcc_map.vh - constants for the dual comparator control block
// assumes: included by bare name from the design files
`ifndef DCC_MAP_VH
`define DCC_MAP_VH

`define DCC_CTRL_RESET      8'h00
`define DCC_MODE_LSB        0
`define DCC_MODE_MSB        2
`define DCC_INPUT_SEL_BIT   3
`define DCC_INV1_BIT        4
`define DCC_INV2_BIT        5
`define DCC_RES1_BIT        6
`define DCC_RES2_BIT        7
`define DCC_WR_MASK         8'h3F
`define DCC_FLAG_BIT        6

`define DCC_MODE_RESET      3'h0
`define DCC_MODE_OUT_A      3'h1
`define DCC_MODE_INTREF     3'h2
`define DCC_MODE_OUT_B      3'h6
`define DCC_MODE_OFF        3'h7

`define DCC_SYNC_STAGES     2

`endif

// ===== dcc_sync.v
// dcc_sync.v - two-stage synchroniser for one asynchronous level
// assumes: d_in may change at any time relative to clk_in
`timescale 1ns/1ns
module dcc_sync (
    input  wire clk_in,
    input  wire rst_in,
    input  wire d_in,
    output wire q_out
);
    reg meta_ff;
    reg sync_ff;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule // dcc_sync

// ===== dcc_top.v
// dcc_top.v - control logic of a dual analog comparator unit
// assumes: analog results arrive asynchronous; cpu access strobes are one-cycle pulses on clk_in
// Summary of operation
// RL1 - three-bit mode field selects eight configurations
// RL2 - software disables change interrupt during mode change
// RL3 - result low when plus below minus
// RL4 - optional per-comparator output inversion
// RL5 - mode 010 routes internal reference to plus
// RL6 - result bits read-only in upper control bits
// RL7 - modes 110/001 drive pins 3,4 unsynchronized
// RL8 - direction bits still enable those pin outputs
// RL9 - analog-input pins read as zero
// RL10 - change flag sets on output mismatch
// RL11 - software writes flag zero clear, one set
// RL12 - irq needs flag and all three enables
// RL13 - flag set may be lost on read
// RL14 - control access latches outputs, ends mismatch
// RL15 - comparators run in sleep, irq wakes
// RL16 - mode 111 turns both comparators off
// RL17 - reset gives mode 000, comparators powered down
// RL18 - results synchronized for bits and detector
`timescale 1ns/1ns
`include "dcc_map.vh"
module dcc_top (
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       cmp1_raw_in,
    input  wire       cmp2_raw_in,
    input  wire       ctrl_wr_in,
    input  wire       ctrl_rd_in,
    input  wire [7:0] ctrl_wdata_in,
    input  wire       flag_wr_in,
    input  wire       flag_wdata_in,
    input  wire       comparator_change_enable_in,
    input  wire       peripheral_irq_enable_in,
    input  wire       global_irq_enable_in,
    input  wire       sleep_in,
    input  wire [4:0] port_a_direction_in,
    input  wire [4:0] port_latch_in,
    input  wire [4:0] port_pad_in,
    output reg  [7:0] comparator_control_register_out,
    output reg        comparator_change_flag_out,
    output reg        irq_out,
    output reg        wake_out,
    output reg        cmp1_power_out,
    output reg        cmp2_power_out,
    output reg        intref_to_plus_out,
    output reg        input_sel_out,
    output reg  [4:0] pin_out,
    output reg  [4:0] pin_oe_out,
    output reg  [4:0] port_rdata_out
);
    reg  [2:0] mode_ff;
    reg        input_sel_ff;
    reg        inv1_ff;
    reg        inv2_ff;
    reg        latch1_ff;
    reg        latch2_ff;
    reg        flag_ff;
    reg  [2:0] nxt_mode;
    reg        nxt_flag;
    reg  [4:0] analog_mask;
    reg  [4:0] nxt_pin;
    reg        cmp1_on;
    reg        cmp2_on;
    wire       res1_sync;
    wire       res2_sync;
    wire       res1;
    wire       res2;
    wire       out1_raw;
    wire       out2_raw;
    wire       mismatch;
    wire       access;
    wire       pin_route;

    // raw result: high when plus above minus, polarity as supplied by the front end
    dcc_sync u_sync1 ( // RL18
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (cmp1_raw_in), // RL3
        .q_out  (res1_sync)
    );

    dcc_sync u_sync2 ( // RL18
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (cmp2_raw_in), // RL3
        .q_out  (res2_sync)
    );

    // unpowered comparators read as their inversion bit: low unless inverted
    assign res1     = (res1_sync & cmp1_on) ^ inv1_ff; // RL4
    assign res2     = (res2_sync & cmp2_on) ^ inv2_ff; // RL4
    assign out1_raw = (cmp1_raw_in & cmp1_on) ^ inv1_ff; // RL4
    assign out2_raw = (cmp2_raw_in & cmp2_on) ^ inv2_ff; // RL4
    assign mismatch = (res1 != latch1_ff) | (res2 != latch2_ff); // RL10
    assign access   = ctrl_wr_in | ctrl_rd_in;
    assign pin_route = (mode_ff == `DCC_MODE_OUT_B) | (mode_ff == `DCC_MODE_OUT_A); // RL7

    // per-mode power and analog pin usage
    always @* begin
        cmp1_on     = 1'b1;
        cmp2_on     = 1'b1;
        analog_mask = 5'h0F;
        case (mode_ff) // RL1
            `DCC_MODE_RESET: begin
                cmp1_on     = 1'b0;
                cmp2_on     = 1'b0;
                analog_mask = 5'h0F; // RL17
            end
            `DCC_MODE_OUT_A: analog_mask = 5'h07;
            `DCC_MODE_INTREF: analog_mask = 5'h0F; // RL5
            3'h3: analog_mask = 5'h07;
            3'h4: analog_mask = 5'h0F;
            3'h5: begin
                cmp1_on     = 1'b0;
                analog_mask = 5'h06;
            end
            `DCC_MODE_OUT_B: analog_mask = 5'h07;
            `DCC_MODE_OFF: begin
                cmp1_on     = 1'b0; // RL16
                cmp2_on     = 1'b0; // RL16
                analog_mask = 5'h00;
            end
            default: analog_mask = 5'h0F;
        endcase
    end

    // pin drive: comparator results on pins 3 and 4 in routed modes
    always @* begin
        nxt_pin = port_latch_in;
        if (pin_route) begin
            nxt_pin[3] = out1_raw; // RL7
            nxt_pin[4] = out2_raw; // RL7
        end
    end

    always @* begin
        nxt_mode = mode_ff;
        if (ctrl_wr_in) begin
            nxt_mode = ctrl_wdata_in[`DCC_MODE_MSB:`DCC_MODE_LSB]; // RL1
        end
    end

    // hardware set wins over software clear; mismatch persists until access
    always @* begin
        nxt_flag = flag_ff;
        if (flag_wr_in) begin
            nxt_flag = flag_wdata_in; // RL11
        end
        if (mismatch & ~access) begin
            nxt_flag = 1'b1; // RL10 RL13 RL14
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_ff      <= `DCC_MODE_RESET; // RL17
            input_sel_ff <= 1'b0;
            inv1_ff      <= 1'b0;
            inv2_ff      <= 1'b0;
            latch1_ff    <= 1'b0;
            latch2_ff    <= 1'b0;
            flag_ff      <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            flag_ff <= nxt_flag;
            if (ctrl_wr_in) begin
                input_sel_ff <= ctrl_wdata_in[`DCC_INPUT_SEL_BIT];
                inv1_ff      <= ctrl_wdata_in[`DCC_INV1_BIT];
                inv2_ff      <= ctrl_wdata_in[`DCC_INV2_BIT];
            end
            if (access) begin
                latch1_ff <= res1; // RL14
                latch2_ff <= res2; // RL14
            end
        end
    end

    // registered outputs; sleep does not touch control state
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            comparator_control_register_out <= `DCC_CTRL_RESET;
            comparator_change_flag_out      <= 1'b0;
            irq_out                         <= 1'b0;
            wake_out                        <= 1'b0;
            cmp1_power_out                  <= 1'b0; // RL17
            cmp2_power_out                  <= 1'b0; // RL17
            intref_to_plus_out              <= 1'b0;
            input_sel_out                   <= 1'b0;
            pin_out                         <= 5'h00;
            pin_oe_out                      <= 5'h00;
            port_rdata_out                  <= 5'h00;
        end else begin
            comparator_control_register_out <= {res2, res1, inv2_ff, inv1_ff, input_sel_ff, mode_ff}; // RL6
            comparator_change_flag_out      <= flag_ff;
            irq_out <= flag_ff & comparator_change_enable_in
                       & peripheral_irq_enable_in & global_irq_enable_in; // RL12
            wake_out <= sleep_in & flag_ff & comparator_change_enable_in; // RL15
            cmp1_power_out     <= cmp1_on; // RL15 RL16
            cmp2_power_out     <= cmp2_on; // RL15 RL16
            intref_to_plus_out <= (mode_ff == `DCC_MODE_INTREF); // RL5
            input_sel_out      <= input_sel_ff;
            pin_out            <= nxt_pin; // RL7
            pin_oe_out         <= ~port_a_direction_in & ~analog_mask; // RL1 RL8
            port_rdata_out     <= port_pad_in & ~analog_mask; // RL9
        end
    end
endmodule // dcc_top

// ===== dcc_checker.sv
// dcc_checker.sv - port assertions for dcc_top
// assumes: bound into every dcc_top instance
`timescale 1ns/1ns
module dcc_checker (
    input wire       clk_in,
    input wire       rst_in,
    input wire       ctrl_wr_in,
    input wire [7:0] ctrl_wdata_in,
    input wire       sleep_in,
    input wire [4:0] port_a_direction_in,
    input wire [7:0] comparator_control_register_out,
    input wire       comparator_change_flag_out,
    input wire       irq_out,
    input wire       wake_out,
    input wire       cmp1_power_out,
    input wire       cmp2_power_out,
    input wire       intref_to_plus_out,
    input wire [4:0] pin_oe_out,
    input wire [4:0] port_rdata_out
);
    wire [2:0] md;
    assign md = comparator_control_register_out[2:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_reset_clear: assert property ($fell(rst_in) |-> comparator_control_register_out == 8'h00)
        else $error("reset value");
    chk_ctrl_write: assert property (ctrl_wr_in |-> ##2 md == $past(ctrl_wdata_in[2:0], 2))
        else $error("mode write");
    chk_irq_flag: assert property (irq_out |-> comparator_change_flag_out)
        else $error("irq without flag");
    chk_wake_sleep: assert property (wake_out |-> $past(sleep_in))
        else $error("wake outside sleep");
    chk_analog_zero: assert property (md == 3'h0 |-> port_rdata_out[3:0] == 4'h0)
        else $error("analog pin read");
    chk_intref_mode: assert property (intref_to_plus_out == (md == 3'h2))
        else $error("reference route");
    chk_off_mode: assert property (md == 3'h7 |-> !cmp1_power_out && !cmp2_power_out)
        else $error("power in off mode");
    chk_pin_dir: assert property (port_a_direction_in[3] [*3] |-> !pin_oe_out[3])
        else $error("pin enable");
endmodule // dcc_checker

bind dcc_top dcc_checker u_chk (.*);

// ===== dcc_front.sv
// dcc_front.sv - behavioural analog comparator pair
// assumes: bench commands which input is above
`timescale 1ns/1ns
module dcc_front (
    input  wire pwr1_in,
    input  wire pwr2_in,
    input  wire above1_in,
    input  wire above2_in,
    output wire res1_out,
    output wire res2_out
);
    assign res1_out = pwr1_in & above1_in;
    assign res2_out = pwr2_in & above2_in;
endmodule // dcc_front

// ===== dcc_top_test.sv
// dcc_top_test.sv - directed bench for dcc_top
// assumes: dcc_front drives the raw results
`timescale 1ns/1ns
module dcc_top_test;
    reg         clk_in = 1'b0, rst_in = 1'b1, a1 = 1'b0, a2 = 1'b0, wr = 1'b0, rd = 1'b0;
    reg         fw = 1'b0, fd = 1'b0, ce = 1'b0, pe = 1'b0, ge = 1'b0, sl = 1'b0;
    reg  [7:0]  wd = 8'h00;
    reg  [4:0]  dir = 5'h00;
    reg  [39:0] msk = {5'h00, 5'h07, 5'h06, 5'h0F, 5'h07, 5'h0F, 5'h07, 5'h0F};
    wire        c1, c2, fl, irq, wk, p1, p2, ir, isel;
    wire [7:0]  cr;
    wire [4:0]  po, poe, prd;
    integer     fail_count = 0, check_count = 0, i;
    always #5 clk_in = ~clk_in;
    dcc_front u_front (.pwr1_in(p1), .pwr2_in(p2), .above1_in(a1), .above2_in(a2), .res1_out(c1), .res2_out(c2));
    dcc_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .cmp1_raw_in(c1), .cmp2_raw_in(c2), .ctrl_wr_in(wr),
        .ctrl_rd_in(rd), .ctrl_wdata_in(wd), .flag_wr_in(fw), .flag_wdata_in(fd), .sleep_in(sl),
        .comparator_change_enable_in(ce), .peripheral_irq_enable_in(pe), .global_irq_enable_in(ge),
        .port_a_direction_in(dir), .port_latch_in(5'h0A), .port_pad_in(5'h1F), .input_sel_out(isel),
        .comparator_control_register_out(cr), .comparator_change_flag_out(fl), .irq_out(irq), .wake_out(wk),
        .cmp1_power_out(p1), .cmp2_power_out(p2), .intref_to_plus_out(ir), .pin_out(po), .pin_oe_out(poe),
        .port_rdata_out(prd));
    task tk(input integer n);
        repeat (n) @(posedge clk_in);
    endtask
    task chk(input string n, input [7:0] s, e);
        begin
            check_count = check_count + 1;
            if (s !== e) begin
                fail_count = fail_count + 1;
                $display("BAD %0s exp %h seen %h", n, e, s);
            end
        end
    endtask
    // k: 0 control write, 1 control read, 2 flag write
    task acc(input integer k, input [7:0] d);
        begin
            wd <= d;
            fd <= d[0];
            wr <= (k == 0);
            rd <= (k == 1);
            fw <= (k == 2);
            tk(1);
            {wr, rd, fw} <= 3'h0;
            tk(3);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        tk(10);
        rst_in <= 1'b0;
        tk(2);
        chk("ctrl", cr, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            acc(0, i);
            chk("rdata", prd, 5'h1F ^ msk[i*5+:5]);
            chk("iref", ir, i == 2);
            chk("pwr", {p1, p2}, (i == 0 || i == 7) ? 8'h00 : (i == 5) ? 8'h01 : 8'h03);
        end
        $display("modes done");
        a1 <= 1'b1;
        acc(0, 8'hC6);
        tk(6);
        chk("ctrl", cr, 8'h46);
        chk("pins", po[4:3], 8'h01);
        chk("oe", poe[4:3], 8'h03);
        dir <= 5'h18;
        tk(4);
        chk("oe", poe[4:3], 8'h00);
        dir <= 5'h00;
        acc(0, 8'h3E);
        tk(6);
        chk("ctrl", cr, 8'hBE);
        chk("isel", isel, 8'h01);
        chk("pins", po[4:3], 8'h02);
        acc(0, 8'h01);
        tk(6);
        chk("pins", po[4:3], 8'h01);
        $display("pins done");
        acc(1, 0);
        acc(2, 0);
        chk("flag", fl, 0);
        a2 <= 1'b1;
        tk(6);
        chk("flag", fl, 1);
        acc(2, 0);
        tk(2);
        chk("flag", fl, 1);
        acc(1, 0);
        acc(2, 0);
        tk(2);
        chk("flag", fl, 0);
        $display("flag done");
        for (i = 0; i < 8; i = i + 1) begin
            {ce, pe, ge} <= i[2:0];
            acc(2, 1);
            chk("flag", fl, 1);
            chk("irq", irq, i == 7);
        end
        acc(2, 0);
        $display("irq done");
        sl <= 1'b1;
        a1 <= 1'b0;
        tk(6);
        chk("wake", wk, 1);
        chk("ctrl", cr, 8'h81);
        $display("sleep done");
        test_done;
    end
endmodule // dcc_top_test
